// [logic/port_mux_defines.vh]
// constants for the port b / port c alternate-function override block
`ifndef PORT_MUX_DEFINES_VH
`define PORT_MUX_DEFINES_VH

`define NUM_PB_PINS 8
`define NUM_PC_PINS 7
`define NUM_PINS 15
`define PC_BASE 8

`define PB_CAPTURE 0
`define PB_CMP_A1 1
`define PB_SEL 2
`define PB_MOSI 3
`define PB_MISO 4
`define PB_SCK 5
`define PB_OSC_IN 6
`define PB_OSC_OUT 7
`define PC_SDA 12
`define PC_SCL 13
`define PC_RST 14

`define CLK_PERIOD_PS 25000
`define SPIKE_NS 50
`define SPIKE_CYCLES ((`SPIKE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SPIKE_CNT_W 3

`define RST_PIN_VEC 15'h0000
`define RST_LEVEL 1'b0
`define RST_FILT_LEVEL 1'b1

`endif

// [logic/pin_sync.v]
// three-stage pin synchroniser, a change counts once stages two and three agree
`timescale 1ns/1ps
`include "port_mux_defines.vh"

module pin_sync (
  input wire clock,
  input wire sys_rst,
  input wire [`NUM_PINS-1:0] pin_in,
  output wire [`NUM_PINS-1:0] pin_sync_out
);

  reg [`NUM_PINS-1:0] stage1_r;
  reg [`NUM_PINS-1:0] stage2_r;
  reg [`NUM_PINS-1:0] stage3_r;
  reg [`NUM_PINS-1:0] level_r;

  genvar i;
  generate
    for (i = 0; i < `NUM_PINS; i = i + 1)
    begin : g_bit
      always @(posedge clock)
      begin
        if (sys_rst)
        begin
          stage1_r[i] <= `RST_LEVEL;
          stage2_r[i] <= `RST_LEVEL;
          stage3_r[i] <= `RST_LEVEL;
          level_r[i] <= `RST_LEVEL;
        end
        else
        begin
          stage1_r[i] <= pin_in[i];
          stage2_r[i] <= stage1_r[i];
          stage3_r[i] <= stage2_r[i];
          // stage one stays out of this compare on purpose
          if (stage2_r[i] == stage3_r[i])
            level_r[i] <= stage3_r[i];
        end
      end
    end
  endgenerate

  assign pin_sync_out = level_r;

endmodule // pin_sync

// [logic/spike_filter.v]
// spike filter for one two-wire line: a new level must hold for the spike time
`timescale 1ns/1ps
`include "port_mux_defines.vh"

module spike_filter (
  input wire clock,
  input wire sys_rst,
  input wire enable,
  input wire line_in,
  output wire line_out
);

  // full-width copy so the count is cut to the counter width on purpose
  localparam [31:0] hold_full = `SPIKE_CYCLES;
  localparam [`SPIKE_CNT_W-1:0] hold_cycles = hold_full[`SPIKE_CNT_W-1:0];

  reg [`SPIKE_CNT_W-1:0] cnt_r;
  reg level_r;

  always @(posedge clock)
  begin
    if (sys_rst || !enable)
    begin
      cnt_r <= {`SPIKE_CNT_W{1'b0}};
      level_r <= `RST_FILT_LEVEL;
    end
    else if (line_in == level_r)
      cnt_r <= {`SPIKE_CNT_W{1'b0}};
    else if (cnt_r + 1'b1 >= hold_cycles)
    begin
      level_r <= line_in;
      cnt_r <= {`SPIKE_CNT_W{1'b0}};
    end
    else
      cnt_r <= cnt_r + 1'b1;
  end

  assign line_out = level_r;

endmodule // spike_filter

// [logic/port_b_c_alt_function_mux.v]
// alternate-function override and pin resolution for port b and port c
`timescale 1ns/1ps
`include "port_mux_defines.vh"

// Contract
// RULE1: pull-up default 0,1,0 else override value
// RULE2: driver follows direction bit unless overridden
// RULE3: driven level from override or output bit
// RULE4: slave spi forces clock pin to input
// RULE5: master spi forces data-in pin to input
// RULE6: slave spi forces data-out pin to input
// RULE7: slave spi forces select pin to input
// RULE8: external master drives select low to activate
// RULE9: forced input keeps output-bit pull-up, gated
// RULE10: spi data pins swap roles by mode
// RULE11: bit3 value override spi master or timer2
// RULE12: compare outputs need direction bit set
// RULE13: bit0 feeds timer1 input capture
// RULE14: clock fuse drives divided clock on bit0
// RULE15: divided clock continues during reset
// RULE16: bit7 oscillator overrides and pin-change input
// RULE17: bit6 oscillator overrides and pin-change input
// RULE18: each pin feeds its pin-change source
// RULE19: reset fuse makes port c bit6 io
// RULE20: reset pin reads direction, output, input zero
// RULE21: two-wire clock open-drain on port c bit5
// RULE22: two-wire data open-drain on port c bit4
// RULE23: two-wire inputs pass spike filter
// RULE24: overrides recomputed every cycle from enables
module port_b_c_alt_function_mux (
  input wire clock,
  input wire sys_rst,
  input wire [7:0] portb_dir,
  input wire [7:0] portb_out,
  input wire [6:0] portc_dir,
  input wire [6:0] portc_out,
  input wire global_pullup_disable,
  input wire sleep_mode,
  input wire spi_enable_bit,
  input wire spi_master_select,
  input wire spi_sck_out,
  input wire spi_master_data_out,
  input wire spi_slave_data_out,
  input wire timer2_compare_a_en,
  input wire timer2_compare_a_out,
  input wire timer1_compare_a_en,
  input wire timer1_compare_a_out,
  input wire timer1_compare_b_en,
  input wire timer1_compare_b_out,
  input wire clock_output_fuse,
  input wire divided_clock_out,
  input wire internal_rc_selected,
  input wire external_clock_selected,
  input wire async_timer_enable,
  input wire [14:0] pin_change_source,
  input wire pin_change_group0_enable,
  input wire pin_change_group1_enable,
  input wire reset_pin_disable_fuse,
  input wire two_wire_enable,
  input wire two_wire_scl_pull_low,
  input wire two_wire_sda_pull_low,
  input wire [7:0] portb_pin_in,
  input wire [6:0] portc_pin_in,
  output reg [7:0] portb_pin_out,
  output reg [7:0] portb_pin_oe,
  output reg [7:0] portb_pullup_en,
  output reg [6:0] portc_pin_out,
  output reg [6:0] portc_pin_oe,
  output reg [6:0] portc_pullup_en,
  output reg [7:0] portb_in_read,
  output reg [7:0] portb_dir_read,
  output reg [7:0] portb_out_read,
  output reg [6:0] portc_in_read,
  output reg [6:0] portc_dir_read,
  output reg [6:0] portc_out_read,
  output reg [14:0] pin_change_in,
  output reg timer1_capture_in,
  output reg spi_master_data_in,
  output reg spi_slave_data_in,
  output reg spi_sck_in,
  output reg spi_select_n_in,
  output reg two_wire_scl_in,
  output reg two_wire_sda_in,
  output reg two_wire_slew_limit_en
);

  wire [14:0] dir_bits = {portc_dir, portb_dir};
  wire [14:0] out_bits = {portc_out, portb_out};
  wire [14:0] pin_raw = {portc_pin_in, portb_pin_in};
  wire [14:0] pin_level;
  wire scl_filtered;
  wire sda_filtered;

  reg [14:0] pullup_override_en;
  reg [14:0] pullup_override_val;
  reg [14:0] dir_override_en;
  reg [14:0] dir_override_val;
  reg [14:0] value_override_en;
  reg [14:0] value_override_val;
  reg [14:0] din_enable_override_en;
  reg [14:0] din_enable_override_val;
  reg [14:0] pin_group_en;
  reg [14:0] io_hidden;

  reg [14:0] pullup_nxt;
  reg [14:0] oe_nxt;
  reg [14:0] drive_nxt;
  reg [14:0] din_nxt;

  wire spi_master = spi_enable_bit & spi_master_select;
  wire spi_slave = spi_enable_bit & ~spi_master_select;
  wire osc_pin7 = (internal_rc_selected & external_clock_selected) | async_timer_enable;
  wire osc_pin6 = internal_rc_selected | async_timer_enable;
  // fuse unprogrammed leaves the pin to the reset circuit
  wire reset_pin_mode = ~reset_pin_disable_fuse;

  pin_sync u_pin_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .pin_in(pin_raw),
    .pin_sync_out(pin_level)
  );

  // RULE23: spike filter scl
  spike_filter u_scl_filter (
    .clock(clock),
    .sys_rst(sys_rst),
    .enable(two_wire_enable),
    .line_in(pin_level[`PC_SCL]),
    .line_out(scl_filtered)
  );

  // RULE23: spike filter sda
  spike_filter u_sda_filter (
    .clock(clock),
    .sys_rst(sys_rst),
    .enable(two_wire_enable),
    .line_in(pin_level[`PC_SDA]),
    .line_out(sda_filtered)
  );

  // RULE24: overrides purely combinational
  always @*
  begin
    pullup_override_en = 15'h0000;
    pullup_override_val = 15'h0000;
    dir_override_en = 15'h0000;
    dir_override_val = 15'h0000;
    value_override_en = 15'h0000;
    value_override_val = 15'h0000;
    din_enable_override_en = 15'h0000;
    din_enable_override_val = 15'h0000;
    io_hidden = 15'h0000;
    pin_group_en = {{7{pin_change_group1_enable}}, {8{pin_change_group0_enable}}};

    // RULE18: pin-change forces digital input
    din_enable_override_en = pin_change_source & pin_group_en;
    din_enable_override_val = pin_change_source & pin_group_en;

    // RULE16: oscillator pin seven
    if (osc_pin7)
    begin
      pullup_override_en[`PB_OSC_OUT] = 1'b1;
      dir_override_en[`PB_OSC_OUT] = 1'b1;
      din_enable_override_en[`PB_OSC_OUT] = 1'b1;
      din_enable_override_val[`PB_OSC_OUT] = (internal_rc_selected | external_clock_selected) & async_timer_enable;
      io_hidden[`PB_OSC_OUT] = 1'b1;
    end

    // RULE17: oscillator pin six
    if (osc_pin6)
    begin
      pullup_override_en[`PB_OSC_IN] = 1'b1;
      dir_override_en[`PB_OSC_IN] = 1'b1;
      din_enable_override_en[`PB_OSC_IN] = 1'b1;
      din_enable_override_val[`PB_OSC_IN] = internal_rc_selected & async_timer_enable;
      io_hidden[`PB_OSC_IN] = 1'b1;
    end

    // RULE4: clock pin input as slave
    dir_override_en[`PB_SCK] = spi_slave;
    value_override_en[`PB_SCK] = spi_master;
    value_override_val[`PB_SCK] = spi_sck_out;

    // RULE5: data-in pin input as master
    dir_override_en[`PB_MISO] = spi_master;
    // RULE10: slave output on this pin
    value_override_en[`PB_MISO] = spi_slave;
    value_override_val[`PB_MISO] = spi_slave_data_out;

    // RULE6: data-out pin input as slave
    dir_override_en[`PB_MOSI] = spi_slave;
    // RULE11: master output or timer2 compare
    value_override_en[`PB_MOSI] = spi_master | timer2_compare_a_en;
    value_override_val[`PB_MOSI] = (spi_master & spi_master_data_out) | timer2_compare_a_out;

    // RULE7: select pin input as slave
    dir_override_en[`PB_SEL] = spi_slave;
    // RULE12: compare outputs leave direction alone
    value_override_en[`PB_SEL] = timer1_compare_b_en;
    value_override_val[`PB_SEL] = timer1_compare_b_out;
    value_override_en[`PB_CMP_A1] = timer1_compare_a_en;
    value_override_val[`PB_CMP_A1] = timer1_compare_a_out;

    // RULE9: forced input keeps gated pull-up
    if (spi_slave)
    begin
      pullup_override_en[`PB_SCK] = 1'b1;
      pullup_override_val[`PB_SCK] = portb_out[`PB_SCK] & ~global_pullup_disable;
      pullup_override_en[`PB_MOSI] = 1'b1;
      pullup_override_val[`PB_MOSI] = portb_out[`PB_MOSI] & ~global_pullup_disable;
      pullup_override_en[`PB_SEL] = 1'b1;
      pullup_override_val[`PB_SEL] = portb_out[`PB_SEL] & ~global_pullup_disable;
    end
    if (spi_master)
    begin
      pullup_override_en[`PB_MISO] = 1'b1;
      pullup_override_val[`PB_MISO] = portb_out[`PB_MISO] & ~global_pullup_disable;
    end

    // RULE14: clock fuse owns bit zero
    if (clock_output_fuse)
    begin
      dir_override_en[`PB_CAPTURE] = 1'b1;
      dir_override_val[`PB_CAPTURE] = 1'b1;
      value_override_en[`PB_CAPTURE] = 1'b1;
      value_override_val[`PB_CAPTURE] = divided_clock_out;
    end

    // RULE19: reset pin unusable as io
    if (reset_pin_mode)
    begin
      pullup_override_en[`PC_RST] = 1'b1;
      pullup_override_val[`PC_RST] = 1'b1;
      dir_override_en[`PC_RST] = 1'b1;
      din_enable_override_en[`PC_RST] = 1'b1;
      din_enable_override_val[`PC_RST] = 1'b0;
      io_hidden[`PC_RST] = 1'b1;
    end

    // RULE21: scl open-drain, low only
    // RULE22: sda open-drain, low only
    if (two_wire_enable)
    begin
      pullup_override_en[`PC_SCL] = 1'b1;
      pullup_override_val[`PC_SCL] = portc_out[`PC_SCL - `PC_BASE] & ~global_pullup_disable;
      dir_override_en[`PC_SCL] = 1'b1;
      dir_override_val[`PC_SCL] = two_wire_scl_pull_low;
      value_override_en[`PC_SCL] = 1'b1;
      pullup_override_en[`PC_SDA] = 1'b1;
      pullup_override_val[`PC_SDA] = portc_out[`PC_SDA - `PC_BASE] & ~global_pullup_disable;
      dir_override_en[`PC_SDA] = 1'b1;
      dir_override_val[`PC_SDA] = two_wire_sda_pull_low;
      value_override_en[`PC_SDA] = 1'b1;
    end
  end

  // generic resolution, the same for every pin
  genvar i;
  generate
    for (i = 0; i < `NUM_PINS; i = i + 1)
    begin : g_pin
      always @*
      begin
        // RULE1: default pull-up pattern
        if (pullup_override_en[i])
          pullup_nxt[i] = pullup_override_val[i];
        else
          pullup_nxt[i] = ~dir_bits[i] & out_bits[i] & ~global_pullup_disable;
        // RULE2: direction override
        if (dir_override_en[i])
          oe_nxt[i] = dir_override_val[i];
        else
          oe_nxt[i] = dir_bits[i];
        // RULE3: driven level select
        if (value_override_en[i])
          drive_nxt[i] = value_override_val[i];
        else
          drive_nxt[i] = out_bits[i];
        // digital input off in sleep unless overridden
        if (din_enable_override_en[i])
          din_nxt[i] = din_enable_override_val[i] & pin_level[i];
        else
          din_nxt[i] = ~sleep_mode & pin_level[i];
      end
    end
  endgenerate

  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      // pins float in reset except the clock output
      // RULE15: clock out kept through reset
      portb_pin_oe <= {7'h00, clock_output_fuse};
      portb_pin_out <= {7'h00, clock_output_fuse & divided_clock_out};
      portb_pullup_en <= 8'h00;
      portc_pin_out <= 7'h00;
      portc_pin_oe <= 7'h00;
      portc_pullup_en <= 7'h00;
      portb_in_read <= 8'h00;
      portb_dir_read <= 8'h00;
      portb_out_read <= 8'h00;
      portc_in_read <= 7'h00;
      portc_dir_read <= 7'h00;
      portc_out_read <= 7'h00;
      pin_change_in <= `RST_PIN_VEC;
      timer1_capture_in <= 1'b0;
      spi_master_data_in <= 1'b0;
      spi_slave_data_in <= 1'b0;
      spi_sck_in <= 1'b0;
      spi_select_n_in <= 1'b1;
      two_wire_scl_in <= 1'b1;
      two_wire_sda_in <= 1'b1;
      two_wire_slew_limit_en <= 1'b0;
    end
    else
    begin
      portb_pin_oe <= oe_nxt[7:0];
      portb_pin_out <= drive_nxt[7:0];
      portb_pullup_en <= pullup_nxt[7:0];
      portc_pin_oe <= oe_nxt[14:8];
      portc_pin_out <= drive_nxt[14:8];
      portc_pullup_en <= pullup_nxt[14:8];
      // RULE20: hidden pins read zero
      portb_in_read <= din_nxt[7:0] & ~io_hidden[7:0];
      portb_dir_read <= portb_dir & ~io_hidden[7:0];
      portb_out_read <= portb_out & ~io_hidden[7:0];
      portc_in_read <= din_nxt[14:8] & ~io_hidden[14:8];
      portc_dir_read <= portc_dir & ~io_hidden[14:8];
      portc_out_read <= portc_out & ~io_hidden[14:8];
      // RULE18: pin levels to pin-change sources
      pin_change_in <= din_nxt;
      // RULE13: capture input from bit zero
      timer1_capture_in <= din_nxt[`PB_CAPTURE];
      // RULE10: spi inputs by mode
      spi_master_data_in <= spi_master & din_nxt[`PB_MISO];
      spi_slave_data_in <= spi_slave & din_nxt[`PB_MOSI];
      spi_sck_in <= din_nxt[`PB_SCK];
      // RULE8: select low activates slave
      spi_select_n_in <= ~spi_slave | din_nxt[`PB_SEL];
      // RULE23: filtered lines to the interface
      two_wire_scl_in <= scl_filtered;
      two_wire_sda_in <= sda_filtered;
      two_wire_slew_limit_en <= two_wire_enable;
    end
  end

endmodule // port_b_c_alt_function_mux

// [tb/port_mux_checker.sv]
// concurrent checks on the port b / port c override block
`timescale 1ns/1ps
module port_mux_checker (
  input logic clock,
  input logic sys_rst,
  input logic [7:0] portb_dir,
  input logic [7:0] portb_out,
  input logic global_pullup_disable,
  input logic spi_enable_bit,
  input logic spi_master_select,
  input logic spi_master_data_out,
  input logic timer2_compare_a_en,
  input logic timer2_compare_a_out,
  input logic timer1_compare_a_en,
  input logic timer1_compare_a_out,
  input logic clock_output_fuse,
  input logic divided_clock_out,
  input logic async_timer_enable,
  input logic reset_pin_disable_fuse,
  input logic two_wire_enable,
  input logic two_wire_scl_pull_low,
  input logic [7:0] portb_pin_out,
  input logic [7:0] portb_pin_oe,
  input logic [7:0] portb_pullup_en,
  input logic [7:0] portb_dir_read,
  input logic [6:0] portc_pin_out,
  input logic [6:0] portc_pin_oe,
  input logic [6:0] portc_in_read,
  input logic [6:0] portc_dir_read,
  input logic [6:0] portc_out_read,
  input logic two_wire_slew_limit_en
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // outputs are registered once, so each check looks one edge back
  clkout_drive_a: assert property ($past(clock_output_fuse) |-> portb_pin_oe[0]
    && portb_pin_out[0] == $past(divided_clock_out)) else $error("clock output pin wrong");
  spi_slave_a: assert property ($past(spi_enable_bit && !spi_master_select)
    |-> (portb_pin_oe & 8'h2c) == 8'h00) else $error("slave spi pins not inputs");
  slave_pullup_a: assert property (!$past(sys_rst) && $past(spi_enable_bit && !spi_master_select)
    |-> portb_pullup_en[5] == $past(portb_out[5] && !global_pullup_disable)) else $error("forced pull-up wrong");
  master_dir_a: assert property (!$past(sys_rst) && $past(spi_enable_bit && spi_master_select)
    |-> !portb_pin_oe[4] && portb_pin_oe[5] == $past(portb_dir[5])) else $error("master spi pins wrong");
  mosi_value_a: assert property (!$past(sys_rst)
    && $past(spi_enable_bit && spi_master_select && portb_dir[3] && !timer2_compare_a_en)
    |-> portb_pin_out[3] == $past(spi_master_data_out || timer2_compare_a_out)) else $error("mosi value wrong");
  compare_pin_a: assert property (!$past(sys_rst) && $past(timer1_compare_a_en)
    |-> portb_pin_oe[1] == $past(portb_dir[1]) && (!portb_pin_oe[1] || portb_pin_out[1] == $past(timer1_compare_a_out)))
    else $error("compare pin wrong");
  default_pullup_a: assert property (!$past(sys_rst)
    |-> portb_pullup_en[1] == $past(!portb_dir[1] && portb_out[1] && !global_pullup_disable))
    else $error("default pull-up wrong");
  reset_pin_a: assert property ($past(!reset_pin_disable_fuse)
    |-> {portc_dir_read[6], portc_out_read[6], portc_in_read[6], portc_pin_oe[6]} == 4'h0)
    else $error("reset pin not hidden");
  two_wire_a: assert property (!$past(sys_rst) && $past(two_wire_enable)
    |-> portc_pin_oe[5] == $past(two_wire_scl_pull_low) && !portc_pin_out[5] && two_wire_slew_limit_en)
    else $error("two-wire clock drive wrong");
  osc_hidden_a: assert property ($past(async_timer_enable)
    |-> {portb_pin_oe[7:6], portb_pullup_en[7:6], portb_dir_read[7:6]} == 6'h00) else $error("osc pins not hidden");

  cover property (clock_output_fuse);
  cover property (spi_enable_bit && spi_master_select);
  cover property (two_wire_enable && two_wire_scl_pull_low);
endmodule // port_mux_checker

bind port_b_c_alt_function_mux port_mux_checker chk (.*);

// [tb/board_model.sv]
// board model: external drivers, pull-ups and floating pads
`timescale 1ns/1ps
module board_model (
  input logic clock,
  input logic [14:0] oe,
  input logic [14:0] val,
  input logic [14:0] pull,
  input logic [14:0] ext_en,
  input logic [14:0] ext_val,
  output logic [14:0] pad
);
  logic flip_r = 1'b0;
  always @(posedge clock) flip_r <= ~flip_r;
  // a floating pad toggles every clock, so the synchroniser keeps the stale level
  always_comb
    for (int k = 0; k < 15; k++)
      if (k == 12 || k == 13) pad[k] = !((oe[k] && !val[k]) || (ext_en[k] && !ext_val[k]));
      else if (oe[k]) pad[k] = val[k];
      else if (ext_en[k]) pad[k] = ext_val[k];
      else if (pull[k]) pad[k] = 1'b1;
      else pad[k] = flip_r;
endmodule // board_model

// [tb/port_b_c_alt_function_mux_test.sv]
// self-checking bench for the port b / port c override block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin errors++; \
  $display("wrong value %s exp %h got %h", nm, exp, got); end end
module port_b_c_alt_function_mux_test;
  logic clock = 0, sys_rst = 1;
  logic [7:0] portb_dir, portb_out, portb_pin_out, portb_pin_oe, portb_pullup_en;
  logic [7:0] portb_in_read, portb_dir_read, portb_out_read;
  logic [6:0] portc_dir, portc_out, portc_pin_out, portc_pin_oe, portc_pullup_en;
  logic [6:0] portc_in_read, portc_dir_read, portc_out_read;
  logic global_pullup_disable, sleep_mode, spi_enable_bit, spi_master_select, spi_sck_out;
  logic spi_master_data_out, spi_slave_data_out, timer2_compare_a_en, timer2_compare_a_out;
  logic timer1_compare_a_en, timer1_compare_a_out, timer1_compare_b_en, timer1_compare_b_out;
  logic clock_output_fuse, divided_clock_out, internal_rc_selected, external_clock_selected;
  logic async_timer_enable, pin_change_group0_enable, pin_change_group1_enable;
  logic reset_pin_disable_fuse, two_wire_enable, two_wire_scl_pull_low, two_wire_sda_pull_low;
  logic [14:0] pin_change_source, ext_en, ext_val, pad, pin_change_in;
  logic timer1_capture_in, spi_master_data_in, spi_slave_data_in, spi_sck_in, spi_select_n_in;
  logic two_wire_scl_in, two_wire_sda_in, two_wire_slew_limit_en, low_seen;
  wire [7:0] portb_pin_in = pad[7:0];
  wire [6:0] portc_pin_in = pad[14:8];
  int errors = 0, compares = 0, i;

  port_b_c_alt_function_mux uut (.*);
  board_model pcb (.clock(clock), .oe({portc_pin_oe, portb_pin_oe}), .val({portc_pin_out, portb_pin_out}),
    .pull({portc_pullup_en, portb_pullup_en}), .ext_en(ext_en), .ext_val(ext_val), .pad(pad));

  initial forever #12.5 clock = ~clock;

  task automatic clear();
    {portb_dir, portb_out, portc_dir, portc_out, global_pullup_disable, sleep_mode, spi_enable_bit,
      spi_master_select, spi_sck_out, spi_master_data_out, spi_slave_data_out, timer2_compare_a_en,
      timer2_compare_a_out, timer1_compare_a_en, timer1_compare_a_out, timer1_compare_b_en,
      timer1_compare_b_out, clock_output_fuse, divided_clock_out, internal_rc_selected,
      external_clock_selected, async_timer_enable, pin_change_source, pin_change_group0_enable,
      pin_change_group1_enable, reset_pin_disable_fuse, two_wire_enable, two_wire_scl_pull_low,
      two_wire_sda_pull_low, ext_en, ext_val} = '0;
  endtask

  // long enough for the pad synchroniser and the output register
  task automatic settle();
    repeat (8) @(posedge clock);
    #1;
  endtask

  task automatic final_report();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge clock);
    errors++;
    final_report();
  end

  initial
  begin
    clear();
    clock_output_fuse = 1;
    divided_clock_out = 1;
    settle();
    `CHK("rst sel", 1'b1, spi_select_n_in)
    `CHK("rst scl", 1'b1, two_wire_scl_in)
    `CHK("rst divided_clock_out", 2'b11, {portb_pin_oe[0], portb_pin_out[0]})
    repeat (12) @(posedge clock);
    #1;
    sys_rst = 0;
    for (i = 0; i < 8; i++)
    begin
      clear();
      {global_pullup_disable, portb_dir[1], portb_out[1]} = i[2:0];
      settle();
      `CHK("pu b1", ~portb_dir[1] & portb_out[1] & ~global_pullup_disable, portb_pullup_en[1])
      `CHK("oe b1", portb_dir[1], portb_pin_oe[1])
      if (portb_dir[1]) `CHK("in b1", portb_out[1], portb_in_read[1])
    end
    clear();
    portb_dir = 8'h3c;
    portb_out = 8'h3c;
    spi_enable_bit = 1;
    spi_slave_data_out = 1;
    ext_en = 15'h001c;
    // outside master pulls select low, drives mosi high
    ext_val = 15'h0008;
    settle();
    `CHK("slv oe", 8'h10, portb_pin_oe & 8'h3c)
    `CHK("slv pu", 8'h2c, portb_pullup_en & 8'h2c)
    `CHK("slv sel", 1'b0, spi_select_n_in)
    `CHK("slv miso", 1'b1, portb_pin_out[4])
    `CHK("slv din", 2'b10, {spi_slave_data_in, spi_master_data_in})
    `CHK("slv sck", 1'b1, spi_sck_in)
    spi_master_select = 1;
    spi_master_data_out = 1;
    ext_val = 15'h0010;
    settle();
    `CHK("mst oe", 8'h2c, portb_pin_oe & 8'h3c)
    `CHK("mst pu", 1'b1, portb_pullup_en[4])
    `CHK("mst din", 2'b01, {spi_slave_data_in, spi_master_data_in})
    `CHK("mst sel", 1'b1, spi_select_n_in)
    `CHK("mosi", 1'b1, portb_pin_out[3])
    spi_master_data_out = 0;
    timer2_compare_a_en = 1;
    for (i = 0; i < 2; i++)
    begin
      timer2_compare_a_out = i[0];
      settle();
      `CHK("mosi or", i[0], portb_pin_out[3])
    end
    clear();
    {timer1_compare_a_en, timer1_compare_b_en, timer2_compare_a_en} = 3'b111;
    {timer1_compare_a_out, timer1_compare_b_out, timer2_compare_a_out} = 3'b111;
    for (i = 0; i < 2; i++)
    begin
      portb_dir = i[0] ? 8'h0e : 8'h00;
      settle();
      `CHK("cmp oe", i[0] ? 3'b111 : 3'b000, portb_pin_oe[3:1])
      if (i[0]) `CHK("cmp out", 3'b111, portb_pin_out[3:1])
    end
    for (i = 0; i < 2; i++)
    begin
      clear();
      clock_output_fuse = 1;
      divided_clock_out = i[0];
      settle();
      `CHK("divided_clock_out", {1'b1, i[0]}, {portb_pin_oe[0], portb_pin_out[0]})
      clock_output_fuse = 0;
      ext_en = 15'h0001;
      ext_val = {14'h0, i[0]};
      settle();
      `CHK("capture", i[0], timer1_capture_in)
    end
    clear();
    {reset_pin_disable_fuse, sleep_mode, pin_change_group0_enable, pin_change_group1_enable} = 4'hf;
    ext_en = 15'h7fff;
    ext_val = 15'h7fff;
    for (i = 0; i < 16; i++)
    begin
      pin_change_source = (i < 15) ? 15'h1 << i : 15'h7fff;
      if (i == 15) {pin_change_group0_enable, pin_change_group1_enable} = 2'b00;
      settle();
      `CHK("pin_change_source", (i < 15) ? 15'h1 << i : 15'h0, pin_change_in)
    end
    clear();
    portb_dir = 8'hc0;
    portb_out = 8'hc0;
    internal_rc_selected = 1;
    settle();
    `CHK("rc oe", 2'b10, portb_pin_oe[7:6])
    `CHK("rc rd", 4'ha, {portb_out_read[7:6], portb_dir_read[7:6]})
    async_timer_enable = 1;
    settle();
    `CHK("osc", 6'h0, {portb_pin_oe[7:6], portb_dir_read[7:6], portb_pullup_en[7:6]})
    clear();
    portc_dir = 7'h40;
    portc_out = 7'h40;
    settle();
    `CHK("rst pin", 4'h0, {portc_dir_read[6], portc_out_read[6], portc_in_read[6], portc_pin_oe[6]})
    reset_pin_disable_fuse = 1;
    settle();
    `CHK("c6 io", 2'b11, {portc_dir_read[6], portc_pin_oe[6]})
    clear();
    two_wire_enable = 1;
    portc_dir = 7'h30;
    portc_out = 7'h30;
    {two_wire_scl_pull_low, two_wire_sda_pull_low} = 2'b10;
    settle();
    `CHK("scl drv", 4'b1011, {portc_pin_oe[5], portc_pin_out[5], two_wire_slew_limit_en, portc_pullup_en[5]})
    `CHK("tw in", 2'b01, {two_wire_scl_in, two_wire_sda_in})
    {two_wire_scl_pull_low, two_wire_sda_pull_low} = 2'b01;
    settle();
    `CHK("sda drv", 4'b1010, {portc_pin_oe[4], portc_pin_out[4], two_wire_scl_in, two_wire_sda_in})
    ext_en = 15'h2000;
    // one cycle low is below the spike time, two cycles is exactly it
    for (i = 1; i < 3; i++)
    begin
      low_seen = 0;
      repeat (i) @(posedge clock);
      #1;
      ext_en = 15'h0;
      repeat (12)
      begin
        @(posedge clock);
        #1 low_seen = low_seen | !two_wire_scl_in;
      end
      `CHK("spike", i > 1, low_seen)
      ext_en = 15'h2000;
    end
    final_report();
  end
endmodule // port_b_c_alt_function_mux_test
